// ===== rtl/plpc_regs.svh
// constants of the low-power and status LED controller: offsets, fields, resets, timing
// assumes inclusion by bare name from the modules; the package does not include it
//
// Overview of operation
// - energy-detect power-down enabled by strap or by software setting its control bit
// - silent line for some seconds in normal operation enters energy-detect power-down
// - while powered down, watch energy and pulse both line pairs once per second
// - energy seen while powered down returns to normal and starts normal link pulses
// - powered down gates most clocks, keeps reference, selected clock and management
// - a 125 MHz general clock keeps the clock multiplier running while powered down
// - EEE enabled by strap or by software setting gigabit or fast advertise bits
// - link is EEE capable only when both ends advertise it for the resolved speed
// - MAC requests low-power idle on an EEE link with nothing to send; device enters
// - in low-power idle, wake periodically and send refresh signals
// - in low-power idle, watch for remote wake, gate most clocks, keep reference, selected clock and management
// - wake sequence makes data ready within 16 us gigabit or 20 us fast
// - idle entry and exit drop no frame; resume at the established link speed
// - LED pin pulled to supply at reset selects active-low drive, else active-high
// - by default LED lights on link and blinks on activity
// - writes to the three LED control registers override default LED behaviour
// - LED pin level is sampled as a strap at reset before it is driven
// - clearing software power-down returns to normal and brings links up
`ifndef PLPC_REGS_SVH
`define PLPC_REGS_SVH

// register offsets
`define PLPC_ADDR_CTRL2      16'h0015
`define PLPC_ADDR_LED1       16'h001B
`define PLPC_ADDR_LED2       16'h001C
`define PLPC_ADDR_LED3       16'h001D
`define PLPC_ADDR_EEEADV     16'h8001

// field positions
`define PLPC_BIT_EDPD_EN     3
`define PLPC_BIT_EDPD_STAT   1
`define PLPC_BIT_EEE_FAST    1
`define PLPC_BIT_EEE_GIG     2
`define PLPC_BIT_LED_OVR     0
`define PLPC_LED_MODE_LO     2
`define PLPC_BIT_LED_INV     0

// reset values
`define PLPC_RST_REG         16'h0000

// timing
`define PLPC_CLK_MHZ         40
`define PLPC_MS_US           1000
`define PLPC_SEC_MS          1000
`define PLPC_WAKE_GIG_US     16
`define PLPC_WAKE_FAST_US    20
`define PLPC_WAKE_GIG_CYC    (`PLPC_WAKE_GIG_US * `PLPC_CLK_MHZ)
`define PLPC_WAKE_FAST_CYC   (`PLPC_WAKE_FAST_US * `PLPC_CLK_MHZ)
`define PLPC_MS_CYC          (`PLPC_MS_US * `PLPC_CLK_MHZ)
`define PLPC_SILENCE_S       3
`define PLPC_REFRESH_MS      20
`define PLPC_BLINK_MS        80

`endif

// ===== rtl/plpc_pkg.sv
// types of the low-power and status LED controller
// assumes plpc_regs.svh for the numeric constants
package plpc_pkg;
    // power-down mode, one-hot
    typedef enum logic [2:0] {
        PD_NORMAL = 3'b001,
        PD_SOFT   = 3'b010,
        PD_ENERGY = 3'b100
    } plpc_pd_e;

    // EEE transmit state, one-hot
    typedef enum logic [2:0] {
        EE_ACTIVE = 3'b001,
        EE_IDLE   = 3'b010,
        EE_WAKE   = 3'b100
    } plpc_eee_e;

    // one management access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] data;
    } plpc_mgmt_s;

    // LED control register set
    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
        logic [15:0] third;
    } plpc_led_cfg_s;
endpackage

// ===== rtl/plpc_led_drive.sv
// status LED driver: default link/activity, software override, strap-chosen polarity
// assumes msTick is a one-cycle pulse per millisecond on clk_sys
`timescale 1ns/100ps
`include "plpc_regs.svh"
module plpc_led_drive
    import plpc_pkg::*;
#(
    parameter int BLINK_MS = `PLPC_BLINK_MS
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // timing and strap
    input  wire logic          msTick,
    input  wire logic          strapDone,
    input  wire logic          activeLow,
    // link state
    input  wire logic          linkUp,
    input  wire logic          linkActivity,
    input  wire logic          speedGig,
    input  wire logic          duplexFull,
    // configuration
    input  wire plpc_led_cfg_s ledCfg,
    // pin
    output logic               ledOut,
    output logic               ledOe
);
    logic [15:0] blinkCnt;
    logic        blinkPhase;
    logic        actSeen;
    logic        ledOn;

    // blink phase and activity stretch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            blinkCnt   <= 16'h0000;
            blinkPhase <= 1'b0;
            actSeen    <= 1'b0;
        end else begin
            if (linkActivity) actSeen <= 1'b1;
            if (msTick) begin
                if (blinkCnt == 16'(BLINK_MS - 1)) begin
                    blinkCnt   <= 16'h0000;
                    blinkPhase <= ~blinkPhase;
                    if (blinkPhase && !linkActivity) actSeen <= 1'b0;
                end else begin
                    blinkCnt <= blinkCnt + 16'h0001;
                end
            end
        end
    end

    // lit level from default or override
    always_comb begin
        ledOn = linkUp && !(actSeen && blinkPhase);
        if (ledCfg.first[`PLPC_BIT_LED_OVR]) begin
            case (ledCfg.first[`PLPC_LED_MODE_LO +: 2])
                2'h0:    ledOn = linkUp && !(actSeen && blinkPhase);
                2'h1:    ledOn = linkUp && speedGig;
                2'h2:    ledOn = linkUp;
                default: ledOn = linkUp && duplexFull;
            endcase
            case (ledCfg.second[1:0])
                2'h1:    ledOn = 1'b1;
                2'h2:    ledOn = 1'b0;
                default: ledOn = ledOn;
            endcase
        end
    end

    // pin drive stays off until the strap is caught
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ledOut <= 1'b0;
            ledOe  <= 1'b0;
        end else begin
            ledOe  <= strapDone;
            ledOut <= ledOn ^ activeLow ^ ledCfg.third[`PLPC_BIT_LED_INV];
        end
    end
endmodule // plpc_led_drive

// ===== rtl/plpc_top.sv
// low-power mode control and status LED of the transceiver
// assumes synchronous inputs on clk_sys and a decoded management access port
`timescale 1ns/100ps
`include "plpc_regs.svh"
module plpc_top
    import plpc_pkg::*;
#(
    parameter int MS_CYCLES  = `PLPC_MS_CYC,
    parameter int SEC_MS     = `PLPC_SEC_MS,
    parameter int SILENCE_S  = `PLPC_SILENCE_S,
    parameter int REFRESH_MS = `PLPC_REFRESH_MS,
    parameter int BLINK_MS   = `PLPC_BLINK_MS
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // management access
    input  wire plpc_mgmt_s mgmtReq,
    output logic [15:0]     mgmtRdData,
    output logic            mgmtRdValid,
    // strap pins
    input  wire logic       statusLedPinIn,
    input  wire logic       linkStatusPinIn,
    // line and link state
    input  wire logic       softwarePowerdown,
    input  wire logic       lineEnergy,
    input  wire logic       linkUp,
    input  wire logic       speedGig,
    input  wire logic       duplexFull,
    input  wire logic       linkActivity,
    input  wire logic       partnerEeeGig,
    input  wire logic       partnerEeeFast,
    input  wire logic       remoteWake,
    // clock configuration
    input  wire logic       refClkCfgEn,
    input  wire logic       genClkCfgEn,
    input  wire logic       genClk125Sel,
    // MAC side
    input  wire logic       macLpiRequest,
    input  wire logic       macTxPending,
    output logic            lpiActive,
    output logic            dataReady,
    output logic            eeeLink,
    // line pulses
    output logic            linePairAPulse,
    output logic            linePairBPulse,
    output logic            normalPulseEn,
    // power and clocks
    output logic            energyPdActive,
    output logic            clocksGated,
    output logic            cmuEnable,
    output logic            refClkRun,
    output logic            genClkRun,
    output logic            mgmtAvailable,
    // status LED pin
    output logic            statusLedPinOut,
    output logic            statusLedPinOe
);
    plpc_pd_e      pdState;
    plpc_eee_e     eeeState;
    plpc_led_cfg_s ledCfg;
    logic [15:0]   ctrlTwo;
    logic [15:0]   eeeAdv;
    logic          strapDone;
    logic          strapEnergyPd;
    logic          strapEee;
    logic          ledActiveLow;
    logic [31:0]   msCnt;
    logic          msTick;
    logic [15:0]   secCnt;
    logic          secTick;
    logic [15:0]   silenceSec;
    logic [15:0]   refreshCnt;
    logic [15:0]   wakeCnt;
    logic          energyPdEnable;
    logic          localEeeGig;
    logic          localEeeFast;
    logic          next_eeeLink;
    logic          refreshPulse;

    // strap capture one cycle after reset release
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strapDone     <= 1'b0;
            strapEnergyPd <= 1'b0;
            strapEee      <= 1'b0;
            ledActiveLow  <= 1'b0;
        end else if (!strapDone) begin
            strapDone     <= 1'b1;
            ledActiveLow  <= statusLedPinIn;
            strapEnergyPd <= linkStatusPinIn;
            strapEee      <= statusLedPinIn;
        end
    end

    // millisecond and second enables
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            msCnt   <= 32'h0000_0000;
            msTick  <= 1'b0;
            secCnt  <= 16'h0000;
            secTick <= 1'b0;
        end else begin
            msTick  <= (msCnt == 32'(MS_CYCLES - 1));
            msCnt   <= (msCnt == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : msCnt + 32'h0000_0001;
            secTick <= 1'b0;
            if (msTick) begin
                secTick <= (secCnt == 16'(SEC_MS - 1));
                secCnt  <= (secCnt == 16'(SEC_MS - 1)) ? 16'h0000 : secCnt + 16'h0001;
            end
        end
    end

    // management register writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrlTwo <= `PLPC_RST_REG;
            eeeAdv  <= `PLPC_RST_REG;
            ledCfg  <= {`PLPC_RST_REG, `PLPC_RST_REG, `PLPC_RST_REG};
        end else if (mgmtReq.wr) begin
            case (mgmtReq.addr)
                `PLPC_ADDR_CTRL2:  ctrlTwo       <= mgmtReq.data;
                `PLPC_ADDR_EEEADV: eeeAdv        <= mgmtReq.data;
                `PLPC_ADDR_LED1:   ledCfg.first  <= mgmtReq.data;
                `PLPC_ADDR_LED2:   ledCfg.second <= mgmtReq.data;
                `PLPC_ADDR_LED3:   ledCfg.third  <= mgmtReq.data;
                default:           ctrlTwo       <= ctrlTwo;
            endcase
        end
    end

    // management reads, one cycle later; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mgmtRdData  <= 16'h0000;
            mgmtRdValid <= 1'b0;
        end else begin
            mgmtRdValid <= mgmtReq.rd;
            if (mgmtReq.rd) begin
                case (mgmtReq.addr)
                    `PLPC_ADDR_CTRL2: begin
                        mgmtRdData <= ctrlTwo;
                        mgmtRdData[`PLPC_BIT_EDPD_STAT] <= (pdState == PD_ENERGY);
                    end
                    `PLPC_ADDR_EEEADV: mgmtRdData <= eeeAdv;
                    `PLPC_ADDR_LED1:   mgmtRdData <= ledCfg.first;
                    `PLPC_ADDR_LED2:   mgmtRdData <= ledCfg.second;
                    `PLPC_ADDR_LED3:   mgmtRdData <= ledCfg.third;
                    default:           mgmtRdData <= 16'h0000;
                endcase
            end
        end
    end

    // enables from strap or software
    assign energyPdEnable = strapEnergyPd || ctrlTwo[`PLPC_BIT_EDPD_EN];
    assign localEeeGig    = strapEee || eeeAdv[`PLPC_BIT_EEE_GIG];
    assign localEeeFast   = strapEee || eeeAdv[`PLPC_BIT_EEE_FAST];
    assign next_eeeLink   = linkUp && (speedGig ? (localEeeGig && partnerEeeGig)
                                                : (localEeeFast && partnerEeeFast));

    // power-down mode sequence
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pdState <= PD_NORMAL;
        end else begin
            case (pdState)
                PD_NORMAL: begin
                    if (softwarePowerdown) pdState <= PD_SOFT;
                    else if (energyPdEnable && !lineEnergy &&
                             silenceSec >= 16'(SILENCE_S)) pdState <= PD_ENERGY;
                end
                PD_SOFT: begin
                    if (!softwarePowerdown) pdState <= PD_NORMAL;
                end
                PD_ENERGY: begin
                    if (softwarePowerdown) pdState <= PD_SOFT;
                    else if (lineEnergy || !energyPdEnable) pdState <= PD_NORMAL;
                end
                default: pdState <= PD_NORMAL;
            endcase
        end
    end

    // seconds of silence seen in normal operation
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            silenceSec <= 16'h0000;
        end else if (pdState != PD_NORMAL || lineEnergy) begin
            silenceSec <= 16'h0000;
        end else if (secTick && silenceSec != 16'hFFFF) begin
            silenceSec <= silenceSec + 16'h0001;
        end
    end

    // line pulses and mode outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            linePairAPulse <= 1'b0;
            linePairBPulse <= 1'b0;
            normalPulseEn  <= 1'b0;
            energyPdActive <= 1'b0;
            clocksGated    <= 1'b0;
            cmuEnable      <= 1'b0;
            refClkRun      <= 1'b0;
            genClkRun      <= 1'b0;
            mgmtAvailable  <= 1'b0;
        end else begin
            linePairAPulse <= ((pdState == PD_ENERGY) && secTick) || refreshPulse;
            linePairBPulse <= ((pdState == PD_ENERGY) && secTick) || refreshPulse;
            normalPulseEn  <= (pdState == PD_NORMAL);
            energyPdActive <= (pdState == PD_ENERGY);
            clocksGated    <= (pdState != PD_NORMAL) || (eeeState == EE_IDLE);
            cmuEnable      <= ((pdState == PD_NORMAL) && (eeeState != EE_IDLE))
                              || (genClkCfgEn && genClk125Sel);
            refClkRun      <= refClkCfgEn;
            genClkRun      <= genClkCfgEn;
            mgmtAvailable  <= 1'b1;
        end
    end

    // EEE low-power idle sequence; idle is taken only with nothing pending
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            eeeState <= EE_ACTIVE;
        end else if (!next_eeeLink || pdState != PD_NORMAL) begin
            eeeState <= EE_ACTIVE;
        end else begin
            case (eeeState)
                EE_ACTIVE: begin
                    if (macLpiRequest && !macTxPending) eeeState <= EE_IDLE;
                end
                EE_IDLE: begin
                    if (!macLpiRequest || macTxPending || remoteWake)
                        eeeState <= EE_WAKE;
                end
                EE_WAKE: begin
                    if (wakeCnt == 16'h0000) eeeState <= EE_ACTIVE;
                end
                default: eeeState <= EE_ACTIVE;
            endcase
        end
    end

    // wake countdown for the resolved speed
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wakeCnt <= 16'h0000;
        end else if (eeeState != EE_WAKE) begin
            wakeCnt <= speedGig ? 16'(`PLPC_WAKE_GIG_CYC - 2)
                                : 16'(`PLPC_WAKE_FAST_CYC - 2);
        end else if (wakeCnt != 16'h0000) begin
            wakeCnt <= wakeCnt - 16'h0001;
        end
    end

    // refresh spacing and EEE outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            refreshCnt <= 16'h0000;
            lpiActive  <= 1'b0;
            dataReady  <= 1'b0;
            eeeLink    <= 1'b0;
        end else begin
            eeeLink   <= next_eeeLink;
            lpiActive <= (eeeState == EE_IDLE);
            dataReady <= linkUp && (pdState == PD_NORMAL) && (eeeState == EE_ACTIVE);
            if (eeeState != EE_IDLE) refreshCnt <= 16'h0000;
            else if (msTick) begin
                refreshCnt <= (refreshCnt == 16'(REFRESH_MS - 1)) ? 16'h0000
                                                                  : refreshCnt + 16'h0001;
            end
        end
    end

    // refresh signal once per refresh interval, sent on both pairs
    always_ff @(posedge clk_sys) begin
        if (reset) refreshPulse <= 1'b0;
        else refreshPulse <= (eeeState == EE_IDLE) && msTick &&
                             (refreshCnt == 16'(REFRESH_MS - 1));
    end

    // status LED
    plpc_led_drive #(
        .BLINK_MS     (BLINK_MS)
    ) u_led (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .msTick       (msTick),
        .strapDone    (strapDone),
        .activeLow    (ledActiveLow),
        .linkUp       (linkUp),
        .linkActivity (linkActivity),
        .speedGig     (speedGig),
        .duplexFull   (duplexFull),
        .ledCfg       (ledCfg),
        .ledOut       (statusLedPinOut),
        .ledOe        (statusLedPinOe)
    );

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_ctrl_write: assert property (
        mgmtReq.wr && mgmtReq.addr == `PLPC_ADDR_CTRL2 && mgmtReq.data[`PLPC_BIT_EDPD_EN]
        |=> energyPdEnable)
        else $error("energy-detect enable not taken");
    chk_edpd_enter: assert property (
        pdState == PD_NORMAL && !softwarePowerdown && energyPdEnable && !lineEnergy
        && silenceSec >= 16'(SILENCE_S) |=> pdState == PD_ENERGY)
        else $error("silent line did not power down");
    chk_pulse_pairs: assert property (
        linePairAPulse |-> linePairBPulse
        && (($past(pdState == PD_ENERGY) && $past(secTick)) || $past(refreshPulse)))
        else $error("line pulse outside power-down or idle, or unpaired");
    chk_edpd_exit: assert property (
        pdState == PD_ENERGY && lineEnergy && !softwarePowerdown |=> pdState == PD_NORMAL
        ##1 normalPulseEn)
        else $error("energy did not wake the device");
    chk_cmu_hold: assert property (
        genClkCfgEn && genClk125Sel |=> cmuEnable)
        else $error("clock multiplier stopped with 125 MHz output");
    chk_lpi_entry: assert property (
        eeeState == EE_ACTIVE ##1 eeeState == EE_IDLE |-> $past(next_eeeLink)
        && $past(!macTxPending))
        else $error("idle entered without EEE link");
    chk_refresh_idle: assert property (
        refreshPulse |-> $past(eeeState == EE_IDLE))
        else $error("refresh outside idle");
    chk_wake_gig: assert property (
        eeeState == EE_IDLE ##1 eeeState == EE_WAKE && speedGig && next_eeeLink
        && pdState == PD_NORMAL |-> ##[1:640] eeeState != EE_WAKE)
        else $error("gigabit wake too slow");
    chk_led_strap: assert property (
        !strapDone |=> !statusLedPinOe)
        else $error("LED driven before strap capture");
    chk_swpd_exit: assert property (
        pdState == PD_SOFT && !softwarePowerdown |=> pdState == PD_NORMAL)
        else $error("software power-down not left");

    cov_edpd: cover property (pdState == PD_NORMAL ##1 pdState == PD_ENERGY);
    cov_lpi: cover property (eeeState == EE_ACTIVE ##1 eeeState == EE_IDLE);
    cov_wake: cover property (eeeState == EE_WAKE ##1 eeeState == EE_ACTIVE);
    cov_pulse: cover property (linePairAPulse);
endmodule // plpc_top

// ===== testbench/plpc_mac_partner.sv
// behavioural MAC on the far side of the low-power idle handshake
// assumes the bench sets idleWanted and sendData; outputs change on the falling edge
`timescale 1ns/100ps
module plpc_mac_partner (
    // clock
    input  wire logic clk_sys,
    // link state from the device
    input  wire logic eeeLink,
    // bench intent
    input  wire logic idleWanted,
    input  wire logic sendData,
    // MAC requests
    output logic      macLpiRequest,
    output logic      macTxPending
);
    // idle asked only on an EEE link with nothing queued
    always @(negedge clk_sys) begin
        macTxPending  <= sendData;
        macLpiRequest <= eeeLink && idleWanted && !sendData;
    end
endmodule // plpc_mac_partner

// ===== testbench/plpc_top_bench.sv
// self-checking bench of the low-power and status LED controller
// assumes shortened timing parameters; one second is 16 cycles here
`timescale 1ns/100ps
module plpc_top_bench;
    import plpc_pkg::*;
    logic clk_sys = 1'b0, reset, statusLedPinIn, linkStatusPinIn, softwarePowerdown;
    logic lineEnergy, linkUp, speedGig, duplexFull, linkActivity, partnerEeeGig;
    logic partnerEeeFast, remoteWake, refClkCfgEn, genClkCfgEn, genClk125Sel;
    logic macLpiRequest, macTxPending, lpiActive, dataReady, eeeLink, idleWanted, sendData;
    logic linePairAPulse, linePairBPulse, normalPulseEn, energyPdActive, clocksGated;
    logic cmuEnable, refClkRun, genClkRun, mgmtAvailable, statusLedPinOut, statusLedPinOe;
    logic mgmtRdValid;
    logic [15:0] mgmtRdData, d;
    plpc_mgmt_s mgmtReq;
    int errors = 0, cmpCount = 0, cyc = 0, n;

    // design with one second of 16 cycles
    plpc_top #(.MS_CYCLES(4), .SEC_MS(4), .SILENCE_S(1), .REFRESH_MS(2), .BLINK_MS(2)) uut (
        .clk_sys, .reset, .mgmtReq, .mgmtRdData, .mgmtRdValid, .statusLedPinIn,
        .linkStatusPinIn, .softwarePowerdown, .lineEnergy, .linkUp, .speedGig, .duplexFull,
        .linkActivity, .partnerEeeGig, .partnerEeeFast, .remoteWake, .refClkCfgEn,
        .genClkCfgEn, .genClk125Sel, .macLpiRequest, .macTxPending, .lpiActive, .dataReady,
        .eeeLink, .linePairAPulse, .linePairBPulse, .normalPulseEn, .energyPdActive,
        .clocksGated, .cmuEnable, .refClkRun, .genClkRun, .mgmtAvailable, .statusLedPinOut,
        .statusLedPinOe);
    plpc_mac_partner mac (.clk_sys, .eeeLink, .idleWanted, .sendData, .macLpiRequest,
        .macTxPending);

    // 40 MHz clock and hang guard
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (errors == 0 && cmpCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    // reset held 16 cycles, then strap and pin settle
    task automatic doReset();
        reset = 1'b1;
        tick(16);
        reset = 1'b0;
        tick(3);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk_sys);
        mgmtReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
        @(negedge clk_sys);
        mgmtReq.wr = 1'b0;
        tick(2);
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(negedge clk_sys);
        mgmtReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
        @(negedge clk_sys);
        mgmtReq.rd = 1'b0;
        chk(mgmtRdValid, 1'b1);
        v = mgmtRdData;
    endtask

    // idle entry, refresh, then wake by request drop, queued data or remote wake
    task automatic lpiCycle(input int wakeCyc, input logic [1:0] how);
        int k;
        idleWanted = 1'b1;
        for (k = 0; k < 10 && lpiActive !== 1'b1; k++) tick(1);
        chk(lpiActive, 1'b1);
        chk(dataReady, 1'b0);
        chk(refClkRun, 1'b1);
        rd(16'h001B, d);
        chk(d, 16'h0000);
        for (k = 0; k < 40 && linePairAPulse !== 1'b1; k++) tick(1);
        chk(linePairAPulse, 1'b1);
        chk(linePairBPulse, 1'b1);
        if (how == 2'd1) sendData = 1'b1;
        else if (how == 2'd2) remoteWake = 1'b1;
        else idleWanted = 1'b0;
        for (k = 0; k < 1000 && dataReady !== 1'b1; k++) tick(1);
        chk(k >= wakeCyc && k <= wakeCyc + 8, 1'b1);
        idleWanted = 1'b0;
        sendData = 1'b0;
        remoteWake = 1'b0;
        tick(3);
    endtask

    initial begin
        mgmtReq = '0;
        {statusLedPinIn, linkStatusPinIn, softwarePowerdown, lineEnergy, linkUp} = '0;
        {duplexFull, linkActivity, partnerEeeFast, remoteWake, idleWanted, sendData} = '0;
        {speedGig, partnerEeeGig, refClkCfgEn, genClkCfgEn, genClk125Sel} = '1;
        reset = 1'b1;
        doReset();
        chk(mgmtAvailable, 1'b1);
        chk(statusLedPinOe, 1'b1);
        rd(16'h001B, d);
        chk(d, 16'h0000);
        rd(16'h0002, d);
        chk(d, 16'h0000);
        // silent line with software enable
        wr(16'h0015, 16'h0008);
        for (n = 0; n < 60 && energyPdActive !== 1'b1; n++) tick(1);
        chk(energyPdActive, 1'b1);
        chk(clocksGated, 1'b1);
        chk(genClkRun, 1'b1);
        chk(cmuEnable, 1'b1);
        rd(16'h0015, d);
        chk(d[1], 1'b1);
        for (n = 0; n < 40 && linePairAPulse !== 1'b1; n++) tick(1);
        chk(linePairAPulse, 1'b1);
        chk(linePairBPulse, 1'b1);
        lineEnergy = 1'b1;
        tick(3);
        chk(energyPdActive, 1'b0);
        chk(normalPulseEn, 1'b1);
        softwarePowerdown = 1'b1;
        tick(3);
        chk(normalPulseEn, 1'b0);
        softwarePowerdown = 1'b0;
        tick(3);
        chk(normalPulseEn, 1'b1);
        // EEE capability and idle
        linkUp = 1'b1;
        tick(3);
        chk(eeeLink, 1'b0);
        chk(statusLedPinOut, 1'b1);
        wr(16'h8001, 16'h0004);
        chk(eeeLink, 1'b1);
        {partnerEeeGig, partnerEeeFast} = 2'b01;
        tick(3);
        chk(eeeLink, 1'b0);
        partnerEeeGig = 1'b1;
        tick(3);
        lpiCycle(640, 2'd0);
        lpiCycle(640, 2'd1);
        wr(16'h8001, 16'h0006);
        speedGig = 1'b0;
        tick(3);
        lpiCycle(800, 2'd0);
        lpiCycle(800, 2'd2);
        // LED activity and override
        linkActivity = 1'b1;
        for (n = 0; n < 30 && statusLedPinOut !== 1'b0; n++) tick(1);
        chk(statusLedPinOut, 1'b0);
        linkActivity = 1'b0;
        wr(16'h001B, 16'h000D);
        chk(statusLedPinOut, 1'b0);
        duplexFull = 1'b1;
        tick(3);
        chk(statusLedPinOut, 1'b1);
        wr(16'h001D, 16'h0001);
        wr(16'h001B, 16'h0005);
        chk(statusLedPinOut, 1'b1);
        // second reset with the LED pin pulled to supply
        statusLedPinIn = 1'b1;
        speedGig = 1'b1;
        reset = 1'b1;
        tick(2);
        chk(statusLedPinOe, 1'b0);
        doReset();
        chk(eeeLink, 1'b1);
        chk(statusLedPinOut, 1'b0);
        rd(16'h001D, d);
        chk(d, 16'h0000);
        end_sim();
    end
endmodule // plpc_top_bench
